//--- inc/fewc_pkg.sv
// Package for the flash and data EEPROM write controller
// Assumes a single 125 MHz core clock and a synchronous active-low reset
`default_nettype none
package fewc_pkg;
	// Register offsets on the special function register port
	localparam logic [7:0] OFS_CMD_PORT = 8'h97;
	localparam logic [7:0] OFS_PERMIT = 8'hc9;
	localparam logic [7:0] OFS_AUXILIARY_CONTROL_TWO = 8'hf7;
	localparam logic [7:0] OFS_IRQ_STAT = 8'hb4;
	localparam logic [7:0] OFS_IRQ_MASK = 8'hb5;
	// Command and permit codes
	localparam logic [7:0] CODE_UNLOCK = 8'h65;
	localparam logic [7:0] CODE_FLASH_PERMIT = 8'h47;
	localparam logic [7:0] CODE_EE_PERMIT = 8'he2;
	// Field positions
	localparam int BIT_RANGE = 0;
	localparam int BIT_FLASH_PERMIT = 7;
	localparam int BIT_TIMEOUT = 6;
	localparam int BIT_EE_PERMIT = 5;
	localparam int SEL_LO = 1;
	localparam int SEL_HI = 2;
	localparam logic [7:0] AUXILIARY_CONTROL_TWO_RESET = 8'h06;
	// Address map
	localparam logic [15:0] FREE_BASE = 16'h1f00;
	localparam logic [15:0] FULL_TOP = 16'h1fef;
	localparam logic [15:0] EE_BASE = 16'hee00;
	localparam logic [15:0] EE_TOP = 16'heefe;
	localparam int EE_WORDS = 128;
	// Timing in microseconds and nanoseconds
	localparam int CLK_MHZ = 125;
	localparam int WRITE_US = 1000;
	localparam int TO1_US = 1600;
	localparam int TO2_US = 3200;
	localparam int TO3_US = 12800;
	localparam int EE_READ_NS = 300;
	localparam int EE_READ_CYC = (EE_READ_NS * CLK_MHZ + 999) / 1000;
	// Interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_TOUT = 1;
	localparam int IRQ_REFUSE = 2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ = 2'b10
	} fewc_state_t;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  data;
	} fewc_xreq_t;
endpackage
`default_nettype wire

//--- rtl/fewc_ctrl.sv
// Write controller for program flash and a 128-byte data EEPROM
// Assumes the core stalls on core_wait and drives single-cycle strobes
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Unlock code on command port widens flash range; range bit reads 1.
// - Any other command value restricts flash writes to free area; bit reads 0.
// - Range bit 0 refuses writes to lower program area; 1 accepts them.
// - Flash permit code sets flash permit flag, read in bit 7.
// - EEPROM permit code sets EEPROM permit flag, read in bit 5.
// - Any other permit value clears both permit flags together.
// - Timeout flag bit 6 set on timeout, cleared when permission clears.
// - Select 00 off; 01,10,11 time out after 1.6, 3.2, 12.8 ms.
// - Sequence: timeout, optional unlock, permit, data write; core stalls.
// - EEPROM holds 128 bytes at even addresses EE00h to EEFEh.
// - EEPROM write stalls core about 1 ms; peripherals keep running.
// - EEPROM write shares timeout mechanism and flag with flash.
// - EEPROM read returns stored byte in about 300 ns.
// - Flash write accepted only while flash permit flag is set.
// - Code-space flash reads add no wait state.
module fewc_ctrl #(
	parameter int WRITE_CYC = fewc_pkg::WRITE_US * fewc_pkg::CLK_MHZ,
	parameter int TO1_CYC = fewc_pkg::TO1_US * fewc_pkg::CLK_MHZ,
	parameter int TO2_CYC = fewc_pkg::TO2_US * fewc_pkg::CLK_MHZ,
	parameter int TO3_CYC = fewc_pkg::TO3_US * fewc_pkg::CLK_MHZ,
	parameter bit CELL_FAIL = 1'b0
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic [7:0]       sfr_addr,
	input  wire logic [7:0]       sfr_wdata,
	input  wire logic             sfr_wr,
	input  wire logic             sfr_rd,
	output logic [7:0]            sfr_rdata,
	input  wire fewc_pkg::fewc_xreq_t xreq,
	output logic [7:0]            xrdata,
	output logic                  xrvalid,
	output logic                  core_wait,
	output logic                  flash_we,
	output logic [15:0]           flash_addr,
	output logic [7:0]            flash_wdata,
	output logic                  irq
);
	localparam int TW = 24;
	localparam int RDW = $clog2(fewc_pkg::EE_READ_CYC);
	localparam int RD_LAST = fewc_pkg::EE_READ_CYC;
	logic [7:0]  ee_mem [fewc_pkg::EE_WORDS];
	logic        range_reg;
	logic        fperm_reg;
	logic        eperm_reg;
	logic        tout_reg;
	logic [7:0]  auxiliary_control_two_reg;
	logic [2:0]  stat_reg;
	logic [2:0]  mask_reg;
	logic        is_ee_reg;
	logic [6:0]  ee_idx_reg;
	logic [7:0]  ee_data_reg;
	logic [RDW-1:0] rd_cnt_reg;
	logic        to_arm_reg;
	logic        wr_timer_load;
	logic        to_timer_load;
	logic        wr_done;
	logic        to_done;
	logic [TW-1:0] to_count;
	fewc_pkg::fewc_state_t state_reg;
	// Inclusive address window test
	function automatic logic in_window(
		input logic [15:0] a,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		return a >= lo && a <= hi;
	endfunction
	// Address decode
	wire         wr_cmd = sfr_wr && sfr_addr == fewc_pkg::OFS_CMD_PORT;
	wire         wr_perm = sfr_wr && sfr_addr == fewc_pkg::OFS_PERMIT;
	wire         wr_auxiliary_control_two = sfr_wr && sfr_addr == fewc_pkg::OFS_AUXILIARY_CONTROL_TWO;
	wire         wr_mask = sfr_wr && sfr_addr == fewc_pkg::OFS_IRQ_MASK;
	wire         rd_stat = sfr_rd && sfr_addr == fewc_pkg::OFS_IRQ_STAT;
	wire [1:0]   to_sel = auxiliary_control_two_reg[fewc_pkg::SEL_HI:fewc_pkg::SEL_LO];
	wire         in_free = in_window(xreq.addr, fewc_pkg::FREE_BASE, fewc_pkg::FULL_TOP);
	wire         in_low = xreq.addr < fewc_pkg::FREE_BASE;
	wire         in_ee = in_window(xreq.addr, fewc_pkg::EE_BASE, fewc_pkg::EE_TOP);
	wire         ee_even = in_ee && !xreq.addr[0];
	wire         idle = state_reg == fewc_pkg::ST_IDLE;
	wire         flash_ok = fperm_reg && (in_free || (range_reg && in_low));
	wire         ee_ok = eperm_reg && ee_even;
	wire         go_flash = idle && xreq.wr && flash_ok;
	wire         go_ee = idle && xreq.wr && ee_ok;
	wire         go_read = idle && xreq.rd && ee_even;
	wire         refused = idle && xreq.wr && (in_free || in_low || in_ee)
		&& !flash_ok && !ee_ok;
	wire         finish = state_reg == fewc_pkg::ST_WRITE && wr_done;
	wire         abandon = state_reg == fewc_pkg::ST_WRITE && to_done && to_arm_reg;
	wire [6:0]   ee_idx = xreq.addr[7:1];
	assign wr_timer_load = go_flash || go_ee;
	assign to_timer_load = (go_flash || go_ee) && to_sel != 2'b00;
	assign to_count = to_sel == 2'b01 ? TW'(TO1_CYC)
		: to_sel == 2'b10 ? TW'(TO2_CYC) : TW'(TO3_CYC);

	fewc_timer #(.W(TW)) u_write_timer (
		.clock   (clock),
		.rst_n   (rst_n),
		.load    (wr_timer_load && !CELL_FAIL),
		.count   (TW'(WRITE_CYC)),
		.expired (wr_done)
	);
	fewc_timer #(.W(TW)) u_timeout_timer (
		.clock   (clock),
		.rst_n   (rst_n),
		.load    (to_timer_load),
		.count   (to_count),
		.expired (to_done)
	);

	// Range and permission flags
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			range_reg <= 1'b0;
			fperm_reg <= 1'b0;
			eperm_reg <= 1'b0;
			auxiliary_control_two_reg <= fewc_pkg::AUXILIARY_CONTROL_TWO_RESET;
			mask_reg <= '0;
		end
		else
		begin
			if (wr_cmd)
				range_reg <= sfr_wdata == fewc_pkg::CODE_UNLOCK;
			if (wr_perm)
			begin
				fperm_reg <= sfr_wdata == fewc_pkg::CODE_FLASH_PERMIT;
				eperm_reg <= sfr_wdata == fewc_pkg::CODE_EE_PERMIT;
			end
			if (wr_auxiliary_control_two)
				auxiliary_control_two_reg <= sfr_wdata;
			if (wr_mask)
				mask_reg <= sfr_wdata[2:0];
		end
	end

	// Timeout flag: set wins over the hardware clear
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			tout_reg <= 1'b0;
		else if (abandon)
			tout_reg <= 1'b1;
		else if (!fperm_reg && !eperm_reg)
			tout_reg <= 1'b0;
	end

	// Write and read sequencing
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_reg <= fewc_pkg::ST_IDLE;
			is_ee_reg <= 1'b0;
			ee_idx_reg <= '0;
			ee_data_reg <= '0;
			rd_cnt_reg <= '0;
			to_arm_reg <= 1'b0;
			core_wait <= 1'b0;
			flash_we <= 1'b0;
			flash_addr <= '0;
			flash_wdata <= '0;
			xrdata <= '0;
			xrvalid <= 1'b0;
		end
		else
		begin
			flash_we <= 1'b0;
			xrvalid <= 1'b0;
			case (state_reg)
				fewc_pkg::ST_IDLE:
				begin
					if (go_flash || go_ee)
					begin
						state_reg <= fewc_pkg::ST_WRITE;
						to_arm_reg <= to_sel != 2'b00;
						core_wait <= 1'b1;
						is_ee_reg <= go_ee;
						ee_idx_reg <= ee_idx;
						ee_data_reg <= xreq.data;
						flash_addr <= xreq.addr;
						flash_wdata <= xreq.data;
					end
					else if (go_read)
					begin
						state_reg <= fewc_pkg::ST_READ;
						core_wait <= 1'b1;
						ee_idx_reg <= ee_idx;
						rd_cnt_reg <= RDW'(fewc_pkg::EE_READ_CYC - 1);
					end
				end
				fewc_pkg::ST_WRITE:
				begin
					if (finish || abandon)
					begin
						state_reg <= fewc_pkg::ST_IDLE;
						core_wait <= 1'b0;
						flash_we <= finish && !is_ee_reg;
					end
				end
				fewc_pkg::ST_READ:
				begin
					if (rd_cnt_reg == '0)
					begin
						state_reg <= fewc_pkg::ST_IDLE;
						core_wait <= 1'b0;
						xrdata <= ee_mem[ee_idx_reg];
						xrvalid <= 1'b1;
					end
					else
						rd_cnt_reg <= rd_cnt_reg - 1'b1;
				end
				default:
				begin
					state_reg <= fewc_pkg::ST_IDLE;
					core_wait <= 1'b0;
				end
			endcase
		end
	end

	// EEPROM array, written only when the cell finishes
	always_ff @(posedge clock)
	begin
		if (finish && is_ee_reg)
			ee_mem[ee_idx_reg] <= ee_data_reg;
	end

	// Interrupt status, read clears, new event wins
	wire [2:0] ev = {refused, abandon, finish};
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			stat_reg <= '0;
		else if (rd_stat)
			stat_reg <= ev;
		else
			stat_reg <= stat_reg | ev;
	end
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(stat_reg & mask_reg);
	end

	// Read port, data one cycle after the strobe
	wire [7:0] perm_view = {fperm_reg, tout_reg, eperm_reg, 5'h00};
	wire [7:0] rd_mux = sfr_addr == fewc_pkg::OFS_CMD_PORT ? {7'h00, range_reg}
		: sfr_addr == fewc_pkg::OFS_PERMIT ? perm_view
		: sfr_addr == fewc_pkg::OFS_AUXILIARY_CONTROL_TWO ? auxiliary_control_two_reg
		: sfr_addr == fewc_pkg::OFS_IRQ_STAT ? {5'h00, stat_reg}
		: sfr_addr == fewc_pkg::OFS_IRQ_MASK ? {5'h00, mask_reg} : 8'h00;
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			sfr_rdata <= '0;
		else if (sfr_rd)
			sfr_rdata <= rd_mux;
	end

	// Code-space reads never reach this block, so they add no wait

	// Range and permission flags
	property p_unlock;
		@(posedge clock) disable iff (!rst_n)
		wr_cmd |=> range_reg == ($past(sfr_wdata) == fewc_pkg::CODE_UNLOCK);
	endproperty
	AST_RANGE: assert property (p_unlock)
		else $error("range flag wrong");
	AST_RESTRICT: assert property (@(posedge clock) disable iff (!rst_n)
		(xreq.wr && idle && in_low && !range_reg) |=> !core_wait)
		else $error("low area write accepted while restricted");
	AST_FPERM: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_perm && sfr_wdata == fewc_pkg::CODE_FLASH_PERMIT) |=> fperm_reg && !eperm_reg)
		else $error("flash permit not set");
	AST_EPERM: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_perm && sfr_wdata == fewc_pkg::CODE_EE_PERMIT) |=> eperm_reg && !fperm_reg)
		else $error("eeprom permit not set");
	AST_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_perm && sfr_wdata != fewc_pkg::CODE_FLASH_PERMIT
		&& sfr_wdata != fewc_pkg::CODE_EE_PERMIT) |=> !fperm_reg && !eperm_reg)
		else $error("permits not cleared");

	// Timeout flag
	AST_TOUT: assert property (@(posedge clock) disable iff (!rst_n)
		abandon |=> tout_reg && !core_wait)
		else $error("timeout not flagged");
	AST_TO_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
		(!fperm_reg && !eperm_reg && !abandon) |=> !tout_reg)
		else $error("timeout flag kept without permission");

	// Write start, refusal and commit
	sequence s_start;
		go_flash || go_ee;
	endsequence
	AST_STALL: assert property (@(posedge clock) disable iff (!rst_n)
		s_start |=> core_wait)
		else $error("core not stalled");
	AST_FREE_OK: assert property (@(posedge clock) disable iff (!rst_n)
		(idle && xreq.wr && fperm_reg && in_free) |=> core_wait)
		else $error("free area write not started");
	AST_EE_GO: assert property (@(posedge clock) disable iff (!rst_n)
		(idle && xreq.wr && eperm_reg && ee_even) |=> core_wait)
		else $error("even eeprom write not started");
	AST_FLASH_REFUSE: assert property (@(posedge clock) disable iff (!rst_n)
		(idle && xreq.wr && !fperm_reg && (in_free || in_low)) |=> !core_wait)
		else $error("flash write started without permission");
	AST_NOSTALL: assert property (@(posedge clock) disable iff (!rst_n)
		(idle && xreq.wr && in_ee && !ee_ok && !flash_ok) |=> !core_wait)
		else $error("odd or unpermitted eeprom write stalled");
	AST_IDLE_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
		(idle && !go_flash && !go_ee && !go_read) |=> !core_wait)
		else $error("core stalled without a started access");
	AST_COMMIT: assert property (@(posedge clock) disable iff (!rst_n)
		(finish && !is_ee_reg) |=> flash_we && !core_wait)
		else $error("flash write not committed");
	AST_EE_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
		(finish && is_ee_reg) |=> !flash_we && !core_wait)
		else $error("eeprom write reached flash pins");

	// EEPROM read: stall for the access time, then one data pulse
	sequence s_read_wait;
		core_wait && !xrvalid;
	endsequence
	sequence s_read_end;
		xrvalid && !core_wait;
	endsequence
	AST_READ: assert property (@(posedge clock) disable iff (!rst_n)
		go_read |=> s_read_wait ##[RD_LAST:RD_LAST] s_read_end)
		else $error("eeprom read timing wrong");
	AST_READ_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == fewc_pkg::ST_READ && rd_cnt_reg != '0) |=> s_read_wait)
		else $error("eeprom read ended early");

	// Interrupt follows unmasked status
	AST_IRQ: assert property (@(posedge clock) disable iff (!rst_n)
		(|(stat_reg & mask_reg)) |=> irq)
		else $error("interrupt not raised");
endmodule
`default_nettype wire

//--- rtl/fewc_timer.sv
// Down counter that times the write cell and the timeout window
// Assumes load comes from the controller state machine; run is set internally by load
`timescale 1ns/1ps
`default_nettype none
module fewc_timer #(
	parameter int W = 24
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              expired
);
	logic [W-1:0] cnt_reg;
	logic         run_reg;
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
		end
		else if (load)
		begin
			cnt_reg <= count;
			run_reg <= 1'b1;
		end
		else if (run_reg && cnt_reg != '0)
			cnt_reg <= cnt_reg - 1'b1;
		else
			run_reg <= 1'b0;
	end
	assign expired = run_reg && (cnt_reg == '0);
endmodule
`default_nettype wire

//--- testbench/fewc_core_model.sv
// Core model: issues data move requests to the write controller
// Assumes the bench waits for idle before launching a new move
`timescale 1ns/1ps
`default_nettype none
module fewc_core_model (
	input  wire logic            clock,
	input  wire logic            stall,
	output var fewc_pkg::fewc_xreq_t xreq
);
	initial xreq = '0;
	// One move, launched only while the core is not stalled
	task automatic movx(input logic wr, input logic [15:0] a, input logic [7:0] d);
		@(negedge clock);
		while (stall !== 1'b0)
			@(negedge clock);
		@(posedge clock);
		xreq <= '{wr, !wr, a, d};
		@(posedge clock);
		xreq <= '{1'b0, 1'b0, ~a, ~d};
	endtask
endmodule
`default_nettype wire

//--- testbench/test_flash_eeprom_write_ctrl.sv
// Self-checking bench: one good controller and one whose cell always fails
// Assumes shortened write and timeout counts set by parameters below
`timescale 1ns/1ps
`default_nettype none
module test_flash_eeprom_write_ctrl;
	localparam int TW = 20;
	logic clock = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0;
	logic [7:0] sfr_addr = '0, sfr_wdata = '0, q0, q1;
	wire [7:0] rdata[2], xrdata[2], fdata[2];
	wire [15:0] faddr[2];
	wire xrvalid[2], cw[2], fwe[2], irq[2];
	logic [23:0] we_ad;
	logic [7:0] xr_seen;
	fewc_pkg::fewc_xreq_t xreq;
	int num_errors = 0, compares = 0, cycles = 0, we_cnt = 0, n0, n1;
	initial forever #4 clock = ~clock;
	for (genvar g = 0; g < 2; g++)
	begin : dut
		fewc_ctrl #(.WRITE_CYC(TW), .TO1_CYC(30), .TO2_CYC(40), .TO3_CYC(50),
			.CELL_FAIL(g == 1)) uut (.clock(clock), .rst_n(rst_n),
			.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
			.sfr_rd(sfr_rd), .sfr_rdata(rdata[g]), .xreq(xreq), .xrdata(xrdata[g]),
			.xrvalid(xrvalid[g]), .core_wait(cw[g]), .flash_we(fwe[g]),
			.flash_addr(faddr[g]), .flash_wdata(fdata[g]), .irq(irq[g]));
	end
	fewc_core_model core (.clock(clock), .stall(cw[0] | cw[1]), .xreq(xreq));
	always @(negedge clock)
	begin
		if (fwe[0] === 1'b1)
		begin
			we_cnt++;
			we_ad = {faddr[0], fdata[0]};
		end
		if (xrvalid[0] === 1'b1)
			xr_seen = xrdata[0];
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("Checks %0d, errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clock);
		sfr_wr <= 1'b0;
	endtask
	task automatic sfr_r(input logic [7:0] a);
		@(posedge clock);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clock);
		sfr_rd <= 1'b0;
		@(negedge clock);
		q0 = rdata[0];
		q1 = rdata[1];
	endtask
	// Issue a move, then count stalled cycles of each controller
	task automatic go(input logic wr, input logic [15:0] a, input logic [7:0] d);
		core.movx(wr, a, d);
		n0 = 0;
		n1 = 0;
		repeat (80)
		begin
			@(negedge clock);
			n0 += int'(cw[0]);
			n1 += int'(cw[1]);
		end
	endtask
	task automatic t_reset();
		sfr_r(fewc_pkg::OFS_CMD_PORT);
		check("range", q0[0], 0);
		sfr_r(fewc_pkg::OFS_PERMIT);
		check("permit", q0[7:5], 0);
		sfr_r(fewc_pkg::OFS_AUXILIARY_CONTROL_TWO);
		check("auxiliary_control_two", q0, fewc_pkg::AUXILIARY_CONTROL_TWO_RESET);
		sfr_r(8'h80);
		check("unmapped", q0, 0);
		check("irq", irq[0], 0);
	endtask
	task automatic t_refuse();
		logic [7:0] pc[3] = '{8'h00, fewc_pkg::CODE_FLASH_PERMIT, fewc_pkg::CODE_EE_PERMIT};
		logic [15:0] ad[3] = '{fewc_pkg::FREE_BASE, 16'h1000, fewc_pkg::EE_BASE + 16'h1};
		for (int i = 0; i < 3; i++)
		begin
			sfr_w(fewc_pkg::OFS_PERMIT, pc[i]);
			go(1'b1, ad[i], 8'h11);
			check("refused stall", n0, 0);
		end
		check("flash_we", we_cnt, 0);
		sfr_r(fewc_pkg::OFS_IRQ_STAT);
		check("refused bit", q0[fewc_pkg::IRQ_REFUSE], 1);
		check("masked irq", irq[0], 0);
	endtask
	task automatic t_flash();
		sfr_w(fewc_pkg::OFS_IRQ_MASK, 8'h01);
		sfr_w(fewc_pkg::OFS_AUXILIARY_CONTROL_TWO, 8'h04);
		sfr_w(fewc_pkg::OFS_CMD_PORT, fewc_pkg::CODE_UNLOCK);
		sfr_r(fewc_pkg::OFS_CMD_PORT);
		check("unlock", q0[0], 1);
		sfr_w(fewc_pkg::OFS_PERMIT, fewc_pkg::CODE_FLASH_PERMIT);
		sfr_r(fewc_pkg::OFS_PERMIT);
		check("flash permit", q0[7:5], 3'b100);
		go(1'b1, 16'h1000, 8'h5a);
		check("write stall", n0 >= TW && n0 <= TW + 2, 1);
		check("commit count", we_cnt, 1);
		check("commit", we_ad, {16'h1000, 8'h5a});
		check("irq up", irq[0], 1);
		sfr_r(fewc_pkg::OFS_IRQ_STAT);
		check("done bit", q0[fewc_pkg::IRQ_DONE], 1);
		@(negedge clock);
		check("irq down", irq[0], 0);
		sfr_w(fewc_pkg::OFS_CMD_PORT, 8'h00);
		sfr_r(fewc_pkg::OFS_CMD_PORT);
		check("relock", q0[0], 0);
		sfr_w(fewc_pkg::OFS_PERMIT, 8'h00);
		sfr_r(fewc_pkg::OFS_PERMIT);
		check("revoke", q0[7:5], 0);
	endtask
	task automatic t_ee();
		logic [15:0] ad[2] = '{fewc_pkg::EE_BASE, fewc_pkg::EE_TOP};
		logic [7:0] dt[2] = '{8'h3c, 8'ha5};
		sfr_w(fewc_pkg::OFS_PERMIT, fewc_pkg::CODE_EE_PERMIT);
		sfr_r(fewc_pkg::OFS_PERMIT);
		check("ee permit", q0[7:5], 3'b001);
		for (int i = 0; i < 2; i++)
		begin
			go(1'b1, ad[i], dt[i]);
			check("ee stall", n0 >= TW && n0 <= TW + 2, 1);
		end
		check("no flash_we", we_cnt, 1);
		sfr_w(fewc_pkg::OFS_PERMIT, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			xr_seen = 8'h00;
			go(1'b0, ad[i], 8'h00);
			check("read time", n0, fewc_pkg::EE_READ_CYC);
			check("read data", xr_seen, dt[i]);
		end
	endtask
	task automatic t_timeout();
		int lim;
		for (int s = 0; s < 4; s++)
		begin
			lim = (s == 1) ? 30 : (s == 2) ? 40 : (s == 3) ? 50 : 80;
			sfr_w(fewc_pkg::OFS_AUXILIARY_CONTROL_TWO, 8'(s << 1));
			sfr_w(fewc_pkg::OFS_PERMIT, (s == 2) ? fewc_pkg::CODE_EE_PERMIT
				: fewc_pkg::CODE_FLASH_PERMIT);
			go(1'b1, (s == 2) ? fewc_pkg::EE_BASE + 16'h2 : fewc_pkg::FREE_BASE, 8'h77);
			check("timeout stall", n1 >= lim && n1 <= lim + 2, 1);
			if (s == 0)
			begin
				// Disabled timeout leaves the failing cell stuck until reset
				@(posedge clock);
				rst_n <= 1'b0;
				repeat (2) @(posedge clock);
				rst_n <= 1'b1;
				sfr_r(fewc_pkg::OFS_AUXILIARY_CONTROL_TWO);
				check("reset wait", cw[1], 0);
				check("auxiliary_control_two again", q0, fewc_pkg::AUXILIARY_CONTROL_TWO_RESET);
			end
			if (s > 0)
			begin
				sfr_r(fewc_pkg::OFS_PERMIT);
				check("timeout flag", {q1[6], q0[6]}, 2'b10);
				sfr_w(fewc_pkg::OFS_PERMIT, 8'h00);
				sfr_r(fewc_pkg::OFS_PERMIT);
				check("flag cleared", q1[6], 0);
			end
		end
	endtask
	initial
	begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_refuse();
		t_flash();
		t_ee();
		t_timeout();
		give_verdict();
	end
endmodule
`default_nettype wire
